// ===== logic/spr_pkg.sv
// Shared constants and carrier types for the serial register front end
package spr_pkg;
    // Build choices
    localparam int DATA_W = 16;
    localparam int SEL_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam bit HOST_MODE = 1'b1;
    // Word addresses
    localparam logic [2:0] ADDR_RX = 3'h0;
    localparam logic [2:0] ADDR_TX = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_RSVD = 3'h4;
    localparam logic [2:0] ADDR_SELMASK = 3'h5;
    localparam logic [2:0] ADDR_EOPMATCH = 3'h6;
    // Status and control bit positions
    localparam int BIT_ROE = 3;
    localparam int BIT_TOE = 4;
    localparam int BIT_TMT = 5;
    localparam int BIT_TRANSMITTER_READY_FLAG = 6;
    localparam int BIT_RECEIVER_READY_FLAG = 7;
    localparam int BIT_ERR = 8;
    localparam int BIT_EOP = 9;
    localparam int BIT_FSEL = 10;
    // Writable control bits; forced select only exists in host mode
    localparam logic [31:0] CTRL_MASK_HOST = 32'h0000_07D8;
    localparam logic [31:0] CTRL_MASK_AGENT = 32'h0000_03D8;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [SEL_W-1:0] SELMASK_RESET = 8'h01;
    // Register bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [31:0] wdata;
    } spr_req_t;
endpackage : spr_pkg

// ===== logic/spr_core.sv
// Register front end of a serial peripheral core, with its receive FIFO
// What this block does
// (R1) Completed received word loads receive holding and sets receiver ready.
// (R2) Reading receive holding clears receiver ready.
// (R3) Writes to receive holding address change nothing.
// (R4) New word loads when holding is free or buffer is full; if receiver ready still set, flag receive overrun.
// (R5) Accepted transmit holding write clears transmitter ready.
// (R6) Shifter taking the holding word sets transmitter ready; next word waits.
// (R7) Transmit write while not ready flags overrun, keeps old holding word.
// (R8) Host should wait for transmitter ready before writing transmit data.
// (R9) Status reads are harmless; status writes clear both overruns and error.
// (R10) Host mode: shifter empty reads 0 while shifting, 1 when idle.
// (R11) Agent mode: shifter empty reads 0 while selected or unable to accept.
// (R12) Error flag is OR of both overrun flags.
// (R13) End-of-packet flag set when read or written data equals match value.
// (R14) Seven word addresses: rx, tx, status, control, reserved, mask, match.
// (R15) Status bits: overruns 3 and 4, empty 5, ready 6 and 7.
// (R16) Control holds interrupt enables at status positions 3, 4 and 6 to 9, forced select at 10.
// (R17) Undefined bits read as anything; writing them changes nothing.
// (R18) Data bits above configured width are undefined.
// (R19) Select mask and forced select exist only in host mode.
// (R20) Interrupt asserted when any flag other than shifter empty and its enable are both set.
// (R21) Reset clears all control bits.
// (R22) Reset sets select mask to agent zero only.
// (R23) Forced select drives masked select outputs continuously.
// (R24) Reserved address reads zero, ignores writes.
`timescale 1ns/1ps
`default_nettype none

module spr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic full;
    logic empty;
    wire logic push = in_valid && !full;
    wire logic pop = out_ready && !empty;
    wire logic [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Fill-side ready is a flop of its own because it leaves the core as a pin
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr];

    // Pointers, count and flags
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
            in_ready <= 1'b1;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= next_count;
            full <= (next_count == (AW+1)'(DEPTH));
            in_ready <= (next_count != (AW+1)'(DEPTH));
            empty <= (next_count == '0);
        end
    end

    // Storage has no reset; contents are qualified by the flags
    always_ff @(posedge sys_clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule : spr_fifo

module spr_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire spr_pkg::spr_req_t req,
    output logic [31:0] rdata,
    // Receive shifter side
    input wire logic rx_word_valid,
    input wire logic [spr_pkg::DATA_W-1:0] rx_word,
    output logic rx_word_ready,
    // Transmit shifter side
    output logic tx_word_valid,
    output logic [spr_pkg::DATA_W-1:0] tx_word,
    input wire logic tx_take,
    input wire logic shift_busy,
    // Select lines
    input wire logic agent_sel_n,
    output logic [spr_pkg::SEL_W-1:0] sel_n,
    // Interrupt
    output logic irq
);
    localparam int DW = spr_pkg::DATA_W;
    localparam logic [31:0] CTRL_WMASK =
        spr_pkg::HOST_MODE ? spr_pkg::CTRL_MASK_HOST : spr_pkg::CTRL_MASK_AGENT;

    // Status word assembly, used by reads and by the interrupt
    // (R15) flag bit placement
    function automatic logic [31:0] status_word(input logic receive_overrun_flag, input logic transmit_overrun_flag,
            input logic shifter_empty_flag, input logic transmitter_ready_flag, input logic receiver_ready_flag, input logic eop);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[spr_pkg::BIT_ROE] = receive_overrun_flag;
        w[spr_pkg::BIT_TOE] = transmit_overrun_flag;
        w[spr_pkg::BIT_TMT] = shifter_empty_flag;
        w[spr_pkg::BIT_TRANSMITTER_READY_FLAG] = transmitter_ready_flag;
        w[spr_pkg::BIT_RECEIVER_READY_FLAG] = receiver_ready_flag;
        w[spr_pkg::BIT_ERR] = receive_overrun_flag | transmit_overrun_flag;
        w[spr_pkg::BIT_EOP] = eop;
        return w;
    endfunction : status_word

    logic [DW-1:0] rx_hold;
    logic [DW-1:0] tx_hold;
    logic rx_full;
    logic tx_full;
    logic receive_overrun_flag;
    logic transmit_overrun_flag;
    logic eop;
    logic [31:0] control;
    logic [spr_pkg::SEL_W-1:0] sel_mask;
    logic [DW-1:0] eop_match;
    logic sel_meta;
    logic sel_sync;
    logic fifo_valid;
    logic [DW-1:0] fifo_data;
    // Drain when holding is free, or force it when the buffer is full (overrun)
    wire logic drain = fifo_valid && (!rx_full || !rx_word_ready);

    // Received words queue here; drain stalls while the holding word is unread and the buffer is not full
    spr_fifo #(.WIDTH(DW), .DEPTH(spr_pkg::FIFO_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(rx_word_valid),
        .in_data(rx_word),
        .in_ready(rx_word_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(drain)
    );

    // Address decode (R14)
    wire logic rd_rx = req.rd && req.addr == spr_pkg::ADDR_RX;
    wire logic wr_tx = req.wr && req.addr == spr_pkg::ADDR_TX;
    wire logic wr_status = req.wr && req.addr == spr_pkg::ADDR_STATUS;
    wire logic wr_control = req.wr && req.addr == spr_pkg::ADDR_CONTROL;
    // (R19) host-only select mask register
    wire logic wr_selmask = req.wr && req.addr == spr_pkg::ADDR_SELMASK && spr_pkg::HOST_MODE;
    wire logic wr_match = req.wr && req.addr == spr_pkg::ADDR_EOPMATCH;
    wire logic tx_accept = wr_tx && !tx_full;
    wire logic tx_refuse = wr_tx && tx_full;
    // (R13) match on read or accepted write
    wire logic eop_hit = (rd_rx && rx_hold == eop_match)
        || (tx_accept && req.wdata[DW-1:0] == eop_match);
    // (R10) host empty flag, (R11) agent empty flag
    wire logic shifter_empty_flag = spr_pkg::HOST_MODE ? !shift_busy : (sel_sync && rx_word_ready);
    wire logic [31:0] stat = status_word(receive_overrun_flag, transmit_overrun_flag, shifter_empty_flag, !tx_full, rx_full, eop);
    wire logic [31:0] next_control = (req.wdata & CTRL_WMASK);
    // (R20) flag and enable both set
    wire logic next_irq = |(stat & control & 32'h0000_03D8);
    // (R23) forced select or active shift drives masked outputs
    wire logic sel_drive = spr_pkg::HOST_MODE && (control[spr_pkg::BIT_FSEL] || shift_busy);
    wire logic [spr_pkg::SEL_W-1:0] next_sel_n = ~(sel_mask & {spr_pkg::SEL_W{sel_drive}});

    // Read mux; (R24) reserved and unmapped read zero, (R18) upper bits zero
    logic [31:0] next_rdata;
    always_comb begin
        unique case (req.addr)
            spr_pkg::ADDR_RX: next_rdata = {{(32-DW){1'b0}}, rx_hold};
            spr_pkg::ADDR_STATUS: next_rdata = stat;
            spr_pkg::ADDR_CONTROL: next_rdata = control;
            spr_pkg::ADDR_SELMASK: next_rdata = {{(32-spr_pkg::SEL_W){1'b0}}, sel_mask};
            spr_pkg::ADDR_EOPMATCH: next_rdata = {{(32-DW){1'b0}}, eop_match};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Agent select pin enters through two flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
        end else begin
            sel_meta <= agent_sel_n;
            sel_sync <= sel_meta;
        end
    end

    // Receive holding and flags; a load in the read cycle keeps ready set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_hold <= '0;
            rx_full <= 1'b0;
            receive_overrun_flag <= 1'b0;
        end else begin
            // (R1) load on arrival, (R4) overrun if unread
            if (drain) rx_hold <= fifo_data;
            if (drain) rx_full <= 1'b1;
            // (R2) read clears ready
            else if (rd_rx) rx_full <= 1'b0;
            if (drain && rx_full) receive_overrun_flag <= 1'b1;
            // (R9) status write clears
            else if (wr_status) receive_overrun_flag <= 1'b0;
        end
    end

    // Transmit holding and flags; no take can happen while empty
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_hold <= '0;
            tx_full <= 1'b0;
            transmit_overrun_flag <= 1'b0;
        end else begin
            // (R5) accepted write fills holding
            if (tx_accept) begin
                tx_hold <= req.wdata[DW-1:0];
                tx_full <= 1'b1;
            // (R6) shifter took the word
            end else if (tx_take) begin
                tx_full <= 1'b0;
            end
            // (R7) refused write flags overrun, holding kept
            if (tx_refuse) transmit_overrun_flag <= 1'b1;
            else if (wr_status) transmit_overrun_flag <= 1'b0;
        end
    end

    // Configuration registers; (R3) and (R17) other writes touch nothing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // (R21) control clear, (R22) first agent selected
            control <= spr_pkg::CTRL_RESET;
            sel_mask <= spr_pkg::SELMASK_RESET;
            eop_match <= '0;
            eop <= 1'b0;
        end else begin
            // (R16) enables and forced select
            if (wr_control) control <= next_control;
            if (wr_selmask) sel_mask <= req.wdata[spr_pkg::SEL_W-1:0];
            if (wr_match) eop_match <= req.wdata[DW-1:0];
            if (eop_hit) eop <= 1'b1;
            else if (wr_status) eop <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
            irq <= 1'b0;
            sel_n <= {spr_pkg::SEL_W{1'b1}};
            tx_word_valid <= 1'b0;
            tx_word <= '0;
        end else begin
            if (req.rd) rdata <= next_rdata;
            irq <= next_irq;
            sel_n <= next_sel_n;
            tx_word_valid <= tx_accept || (tx_full && !tx_take);
            if (tx_accept) tx_word <= req.wdata[DW-1:0];
        end
    end

    // Checks
    property p_rx_load;
        @(posedge sys_clk) disable iff (rst) drain |=> rx_full && rx_hold == $past(fifo_data);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("rx load lost"); // (R1)
    property p_rx_read;
        @(posedge sys_clk) disable iff (rst) rd_rx && !drain |=> !rx_full;
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("rx read no clear"); // (R2)
    property p_rx_wr;
        @(posedge sys_clk) disable iff (rst)
            req.wr && req.addr == spr_pkg::ADDR_RX && !drain |=> $stable(rx_hold) && $stable(control);
    endproperty
    a_rx_wr: assert property (p_rx_wr) else $error("rx write had effect"); // (R3)
    property p_overrun;
        @(posedge sys_clk) disable iff (rst) drain && rx_full |=> receive_overrun_flag ##1 (receive_overrun_flag || $past(wr_status));
    endproperty
    a_overrun: assert property (p_overrun) else $error("rx overrun missed"); // (R4)
    property p_tx_wr;
        @(posedge sys_clk) disable iff (rst) tx_accept |=> tx_full && tx_word_valid;
    endproperty
    a_tx_wr: assert property (p_tx_wr) else $error("tx ready not cleared"); // (R5)
    property p_tx_take;
        @(posedge sys_clk) disable iff (rst) tx_take && !tx_accept |=> !tx_full && !tx_word_valid;
    endproperty
    a_tx_take: assert property (p_tx_take) else $error("tx ready not set"); // (R6)
    property p_tx_ovr;
        @(posedge sys_clk) disable iff (rst) tx_refuse |=> transmit_overrun_flag && $stable(tx_hold);
    endproperty
    a_tx_ovr: assert property (p_tx_ovr) else $error("tx overrun wrong"); // (R7)
    property p_st_clr;
        @(posedge sys_clk) disable iff (rst) wr_status && !tx_refuse && !(drain && rx_full)
            |=> !receive_overrun_flag && !transmit_overrun_flag && !stat[spr_pkg::BIT_ERR];
    endproperty
    a_st_clr: assert property (p_st_clr) else $error("status write no clear"); // (R9)
    property p_err;
        @(posedge sys_clk) disable iff (rst) stat[spr_pkg::BIT_ERR] == (receive_overrun_flag || transmit_overrun_flag);
    endproperty
    a_err: assert property (p_err) else $error("error flag mismatch"); // (R12)
    property p_irq;
        @(posedge sys_clk) disable iff (rst) (rx_full && control[spr_pkg::BIT_RECEIVER_READY_FLAG]) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // (R20)
    property p_fsel;
        @(posedge sys_clk) disable iff (rst)
            spr_pkg::HOST_MODE && control[spr_pkg::BIT_FSEL] |=> sel_n == ~$past(sel_mask);
    endproperty
    a_fsel: assert property (p_fsel) else $error("forced select not driven"); // (R23)
    property p_eop;
        @(posedge sys_clk) disable iff (rst) eop_hit |=> eop;
    endproperty
    a_eop: assert property (p_eop) else $error("end of packet flag missed"); // (R13)
    property p_st_rd;
        @(posedge sys_clk) disable iff (rst) req.rd && req.addr == spr_pkg::ADDR_STATUS && !drain
            |=> $stable(receive_overrun_flag) && $stable(transmit_overrun_flag) && $stable(eop);
    endproperty
    a_st_rd: assert property (p_st_rd) else $error("status read had effect"); // (R9)
    property p_rx_data;
        @(posedge sys_clk) disable iff (rst)
            rd_rx |=> rdata == {{(32-DW){1'b0}}, $past(rx_hold)};
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("rx data read wrong"); // (R14)
    property p_sel_idle;
        @(posedge sys_clk) disable iff (rst) !control[spr_pkg::BIT_FSEL] && !shift_busy
            |=> sel_n == {spr_pkg::SEL_W{1'b1}};
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("select driven while idle"); // (R23)
    c_overrun: cover property (@(posedge sys_clk) disable iff (rst) drain && rx_full);
    c_tx_refuse: cover property (@(posedge sys_clk) disable iff (rst) tx_refuse);
    c_fifo_full: cover property (@(posedge sys_clk) disable iff (rst) !rx_word_ready);
    c_eop: cover property (@(posedge sys_clk) disable iff (rst) eop_hit);
endmodule : spr_core

`default_nettype wire

// ===== test/spr_shift_model.sv
// Behavioural serial shifter on the far side of the register front end
`timescale 1ns/1ps
`default_nettype none
module spr_shift_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bench control
    input wire logic send,
    input wire logic [spr_pkg::DATA_W-1:0] word,
    input wire logic slow,
    output logic [spr_pkg::DATA_W-1:0] last_tx,
    // Core side
    output logic rx_word_valid,
    output logic [spr_pkg::DATA_W-1:0] rx_word,
    input wire logic rx_word_ready,
    input wire logic tx_word_valid,
    input wire logic [spr_pkg::DATA_W-1:0] tx_word,
    output logic tx_take,
    output logic shift_busy
);
    logic [3:0] cnt;
    assign shift_busy = cnt != 4'h0;
    // word held until taken; idle bus shows inverted data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_word_valid <= 1'h0;
            rx_word <= '0;
        end else if (send) begin
            rx_word_valid <= 1'h1;
            rx_word <= word;
        end else if (rx_word_valid && rx_word_ready) begin
            rx_word_valid <= 1'h0;
            rx_word <= ~rx_word;
        end
    end
    // next word taken only after the shift ends
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            tx_take <= 1'h0;
            last_tx <= '0;
        end else begin
            tx_take <= 1'h0;
            if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (tx_word_valid && !tx_take) begin
                tx_take <= 1'h1;
                cnt <= slow ? 4'hF : 4'h3; // Slow shifts leave room to overrun
                last_tx <= tx_word;
            end
        end
    end
endmodule : spr_shift_model
`default_nettype wire

// ===== test/test_spr_core.sv
// Self-checking bench for the serial register front end
`timescale 1ns/1ps
`default_nettype none
module test_spr_core;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    spr_pkg::spr_req_t req = '0;
    logic [31:0] rdata;
    logic send = 1'h0;
    logic slow = 1'h0;
    logic [15:0] word = 16'h0000;
    logic [15:0] last_tx, rx_word, tx_word, w;
    logic rx_word_valid, rx_word_ready, tx_word_valid, tx_take, shift_busy, irq;
    logic [7:0] sel_n;
    logic [2:0] pend;
    logic [31:0] v, d;
    integer fails = 0;
    integer tests_run = 0;
    integer seed = 32'h4C9D;
    integer i, k;
    assign pend = {shift_busy, rx_word_valid, tx_word_valid};
    always #50 sys_clk = ~sys_clk;
    spr_core dut_u (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_word_ready(rx_word_ready),
        .tx_word_valid(tx_word_valid), .tx_word(tx_word), .tx_take(tx_take),
        .shift_busy(shift_busy), .agent_sel_n(1'h1), .sel_n(sel_n), .irq(irq));
    spr_shift_model model_u (.sys_clk(sys_clk), .rst(rst), .send(send), .word(word),
        .slow(slow), .last_tx(last_tx), .rx_word_valid(rx_word_valid),
        .rx_word(rx_word), .rx_word_ready(rx_word_ready), .tx_word_valid(tx_word_valid),
        .tx_word(tx_word), .tx_take(tx_take), .shift_busy(shift_busy));
    // Single exit point of the run
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Receive burst pattern; index 1 repeats the match value
    function automatic logic [15:0] burst_word(input logic [15:0] b, input int n);
        return b ^ 16'h0001 ^ n[15:0];
    endfunction : burst_word
    // Strobes last one cycle; the next call waits for a fresh edge
    task automatic wr(input logic [2:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        req.wr <= 1'h1;
        req.addr <= a;
        req.wdata <= x;
        @(posedge sys_clk);
        req.wr <= 1'h0;
    endtask : wr
    task automatic rchk(input string n, input logic [2:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        req.rd <= 1'h1;
        req.addr <= a;
        @(posedge sys_clk);
        req.rd <= 1'h0;
        #1;
        v = rdata;
        chk(n, e, v);
    endtask : rchk
    // Bounded wait for one pending flag to drop
    task automatic settle(input int s);
        @(negedge sys_clk);
        for (i = 0; i < 99 && pend[s] !== 1'h0; i++) begin
            @(negedge sys_clk);
        end
        if (i == 99) begin
            fails++;
            give_verdict;
        end
    endtask : settle
    task automatic snd(input logic [15:0] x);
        @(posedge sys_clk);
        send <= 1'h1;
        word <= x;
        @(posedge sys_clk);
        send <= 1'h0;
        settle(1);
    endtask : snd
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        rchk("control", 3'h3, 32'h0);
        rchk("select mask", 3'h5, 32'h1);
        rchk("status", 3'h2, 32'h60);
        rchk("reserved", 3'h4, 32'h0);
        wr(3'h4, 32'hFFFF_FFFF);
        rchk("unmapped", 3'h7, 32'h0);
        for (k = 0; k < 3; k++) begin
            d = $random(seed);
            wr(3'h3, d);
            rchk("control", 3'h3, d & 32'h7D8);
        end
        d = $random(seed);
        wr(3'h5, d);
        rchk("select mask", 3'h5, d & 32'hFF);
        wr(3'h3, 32'h400);
        repeat (2) @(negedge sys_clk);
        chk("select", {24'h0, ~d[7:0]}, {24'h0, sel_n});
        wr(3'h3, 32'h40);
        repeat (2) @(negedge sys_clk);
        chk("irq", 32'h1, {31'h0, irq});
        chk("select", 32'hFF, {24'h0, sel_n});
        wr(3'h3, 32'h18);
        repeat (2) @(negedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        // second word waits, late write refused
        slow <= 1'h1;
        d = $random(seed) | 32'h1;
        v = ($random(seed) & 32'h7FFF) | 32'h1;
        w = v[15:0];
        wr(3'h1, d);
        settle(0);
        wr(3'h1, {16'h0, w});
        rchk("status", 3'h2, 32'h0);
        wr(3'h1, {16'h0, ~w});
        rchk("status", 3'h2, 32'h110);
        rchk("status", 3'h2, 32'h110);
        settle(0);
        chk("shifted word", {16'h0, w}, {16'h0, last_tx});
        settle(2);
        wr(3'h2, 32'h0);
        rchk("status", 3'h2, 32'h60);
        slow <= 1'h0;
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            wr(3'h1, d);
            // next write only once transmitter ready
            settle(0);
            chk("shifted word", d & 32'hFFFF, {16'h0, last_tx});
        end
        settle(2);
        // receive, ignored write, end of packet
        w = $random(seed);
        wr(3'h6, {16'h0, w});
        snd(w);
        rchk("status", 3'h2, 32'hE0);
        wr(3'h0, 32'h0);
        rchk("rx data", 3'h0, {16'h0, w});
        rchk("status", 3'h2, 32'h260);
        wr(3'h2, 32'h0);
        // overrun once holding and buffer are full
        for (k = 0; k < 18; k++) begin
            snd(burst_word(w, k));
        end
        rchk("status", 3'h2, 32'h1E8);
        // Two overruns leave word 2 in holding; the rest drain from the buffer in order
        for (k = 2; k < 18; k++) begin
            rchk("rx data", 3'h0, {16'h0, burst_word(w, k)});
        end
        rchk("status", 3'h2, 32'h168);
        chk("receiver ready", 32'h0, {31'h0, v[7]});
        give_verdict;
    end
endmodule : test_spr_core
`default_nettype wire
